/* File: rtl/scc_regs.svh */
// Register indices, field positions, reset values and calendar limits
`ifndef SCC_REGS_SVH
`define SCC_REGS_SVH
`define SCC_SEC       7'h00
`define SCC_MIN       7'h01
`define SCC_HOUR      7'h02
`define SCC_DAY       7'h03
`define SCC_DATE      7'h04
`define SCC_MON       7'h05
`define SCC_YEAR      7'h06
`define SCC_ALM0      7'h07
`define SCC_ALM1      7'h0B
`define SCC_CTRL      7'h0F
`define SCC_STAT      7'h10
`define SCC_RSV_LO    7'h12
`define SCC_CLK_LAST  7'h1F
`define SCC_RAM_FIRST 7'h20
`define SCC_RAM_LAST  7'h7F
`define SCC_PWR_IDX   8'h80
`define SCC_B_A0IE    0
`define SCC_B_A1IE    1
`define SCC_B_INTCN   2
`define SCC_B_OSCOFF  7
`define SCC_B_H12     6
`define SCC_B_PM      5
`define SCC_B_CENT    7
`define SCC_B_MASK    7
`define SCC_B_RW      7
`define SCC_B_F0      0
`define SCC_B_F1      1
`define SCC_ONE       8'h01
`define SCC_XTAL_HZ   32768
`define SCC_BCD_59    8'h59
`define SCC_BCD_23    6'h23
`define SCC_BCD_11    5'h11
`define SCC_BCD_12    5'h12
`define SCC_BCD_99    8'h99
`define SCC_BCD_7     8'h07
`endif

/* File: rtl/scc_pkg.sv */
// Types shared by the calendar clock design
package scc_pkg;
   typedef enum logic [1:0] {LK_IDLE, LK_ADDR, LK_DATA} scc_link_e;
   typedef struct packed {
      logic cs;
      logic sclk;
      logic serial_in_line;
      logic xtal;
      logic mode;
      logic vlow;
      logic vbat;
   } scc_pins_s;
   typedef struct packed {
      scc_pins_s          s1;
      scc_pins_s          s2;
      scc_pins_s          s3;
      scc_pins_s          pin;
      scc_link_e          link;
      logic [2:0]         bits;
      logic               wr;
      logic               idle_hi;
      logic [6:0]         addr;
      logic [7:0]         shin;
      logic [7:0]         shout;
      logic               serial_out_line;
      logic               oe;
      logic [127:0][7:0]  mem;
      logic [6:0][7:0]    shadow;
      logic [15:0]        div;
      logic               tick_d;
      logic               sealed;
      logic               backup;
      logic               ahb_v;
      logic               ahb_w;
      logic [7:0]         ahb_idx;
      logic [31:0]        rdata;
   } scc_state_s;
endpackage : scc_pkg

/* File: rtl/scc_top.sv */
// Serial calendar clock with alarms, battery RAM and supply gating
// Overview of operation
// - Interface select pin picks 3-wire or SPI
// - Device acts only while chip select high
// - Bits shift in step with host clock
// - Shared data line driven only for reads
// - Supply fail output low when main low
// - Time and date kept in BCD
// - Month ends and leap years roll correctly
// - Hours in 24-hour or 12-hour with PM
// - Ninety-six bytes of backed general storage
// - Time advances only with oscillator and supply
// - Two alarms match fields with don't-cares
// - Alarms on two outputs or one merged
// - Single and burst transfers per select period
// - Link access blocked while main supply low
// - Switch to backup below lower threshold
// - Sealed until main first rises above threshold
// - One-second base from crystal reference
// - Burst pointer wraps in clock or RAM
// - Shadow copy on select rise or clock wrap
`timescale 1ns/1ps
`include "scc_regs.svh"
module scc_top #(
   parameter int XTAL_DIV = `SCC_XTAL_HZ
) (
   // Clock and reset
   input  wire logic        MCLK,
   input  wire logic        RST_N,
   // AHB-Lite slave
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   // Serial link
   input  wire logic        CHIP_SELECT_LINE,
   input  wire logic        SERIAL_CLOCK,
   input  wire logic        SERIAL_IN_LINE,
   input  wire logic        INTERFACE_SELECT,
   output logic             SERIAL_OUT_LINE,
   output logic             SERIAL_OUT_OE,
   // Crystal and supply sense
   input  wire logic        XTAL_CLOCK,
   input  wire logic        MAIN_BELOW_THRESHOLD,
   input  wire logic        MAIN_BELOW_BACKUP,
   output logic             SUPPLY_FAIL_N,
   output logic             BACKUP_SELECT,
   // Alarm interrupts
   output logic             ALARM_IRQ_A_N,
   output logic             ALARM_IRQ_B_N
);
   scc_pkg::scc_state_s r;
   scc_pkg::scc_state_s n;
   logic                tick;
   logic                done;
   logic                run;
   logic                samp;
   logic                rise;
   logic                fall;

   function automatic logic [7:0] binc(input logic [7:0] v);
      binc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
   endfunction : binc

   function automatic logic [7:0] maxd(input logic [7:0] mon, input logic [7:0] yr);
      logic leap;
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                   : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
      case (mon[4:0])
         5'h02:                      maxd = leap ? 8'h29 : 8'h28;
         5'h04, 5'h06, 5'h09, 5'h11: maxd = 8'h30;
         default:                    maxd = 8'h31;
      endcase
   endfunction : maxd

   function automatic logic [6:0][7:0] advance(input logic [6:0][7:0] i);
      logic [6:0][7:0] t;
      logic            roll;
      t = i;
      roll = 1'b0;
      if (t[`SCC_SEC] != `SCC_BCD_59) t[`SCC_SEC] = binc(t[`SCC_SEC]);
      else begin
         t[`SCC_SEC] = 8'h00;
         if (t[`SCC_MIN] != `SCC_BCD_59) t[`SCC_MIN] = binc(t[`SCC_MIN]);
         else begin
            t[`SCC_MIN] = 8'h00;
            if (t[`SCC_HOUR][`SCC_B_H12]) begin
               // Day rolls over when 11 PM turns into 12 AM
               if (t[`SCC_HOUR][4:0] == `SCC_BCD_11) begin
                  t[`SCC_HOUR][4:0] = `SCC_BCD_12;
                  roll = t[`SCC_HOUR][`SCC_B_PM];
                  t[`SCC_HOUR][`SCC_B_PM] = ~t[`SCC_HOUR][`SCC_B_PM];
               end else if (t[`SCC_HOUR][4:0] == `SCC_BCD_12) t[`SCC_HOUR][4:0] = 5'h01;
               else t[`SCC_HOUR] = binc(t[`SCC_HOUR]);
            end else if (t[`SCC_HOUR][5:0] == `SCC_BCD_23) begin
               t[`SCC_HOUR][5:0] = 6'h00;
               roll = 1'b1;
            end else t[`SCC_HOUR] = binc(t[`SCC_HOUR]);
         end
      end
      if (roll) begin
         t[`SCC_DAY] = (t[`SCC_DAY] == `SCC_BCD_7) ? `SCC_ONE : binc(t[`SCC_DAY]);
         if (t[`SCC_DATE] != maxd(t[`SCC_MON], t[`SCC_YEAR])) t[`SCC_DATE] = binc(t[`SCC_DATE]);
         else begin
            t[`SCC_DATE] = `SCC_ONE;
            if (t[`SCC_MON][4:0] != `SCC_BCD_12) t[`SCC_MON] = binc(t[`SCC_MON]);
            else begin
               t[`SCC_MON][4:0] = 5'h01;
               if (t[`SCC_YEAR] == `SCC_BCD_99) begin
                  t[`SCC_YEAR] = 8'h00;
                  t[`SCC_MON][`SCC_B_CENT] = ~t[`SCC_MON][`SCC_B_CENT];
               end else t[`SCC_YEAR] = binc(t[`SCC_YEAR]);
            end
         end
      end
      advance = t;
   endfunction : advance

   function automatic logic [7:0] rd(input logic [127:0][7:0] m, input logic [6:0][7:0] sh,
                                     input logic [6:0] a);
      if (a <= `SCC_YEAR) rd = sh[a[2:0]];
      else if (a >= `SCC_RSV_LO && a <= `SCC_CLK_LAST) rd = 8'h00;
      else rd = m[a];
   endfunction : rd

   function automatic logic [127:0][7:0] wr_byte(input logic [127:0][7:0] m, input logic [6:0] a,
                                                 input logic [7:0] d);
      wr_byte = m;
      // Status flags can only be cleared by software, never set
      if (a == `SCC_STAT) wr_byte[a] = m[a] & d;
      else if (a < `SCC_RSV_LO || a > `SCC_CLK_LAST) wr_byte[a] = d;
   endfunction : wr_byte

   function automatic logic [6:0] nxt(input logic [6:0] a);
      if (a == `SCC_CLK_LAST) nxt = `SCC_SEC;
      else if (a == `SCC_RAM_LAST) nxt = `SCC_RAM_FIRST;
      else nxt = a + 7'h01;
   endfunction : nxt

   function automatic logic amatch(input logic [127:0][7:0] m, input logic [6:0] base);
      amatch = 1'b1;
      for (int k = 0; k < 4; k++) begin
         if (!m[base + 7'(k)][`SCC_B_MASK] && m[base + 7'(k)][6:0] != m[k][6:0]) amatch = 1'b0;
      end
   endfunction : amatch

   always_comb begin
      n = r;
      tick = 1'b0;
      done = 1'b0;
      n.s1 = '{CHIP_SELECT_LINE, SERIAL_CLOCK, SERIAL_IN_LINE, XTAL_CLOCK, INTERFACE_SELECT,
               MAIN_BELOW_THRESHOLD, MAIN_BELOW_BACKUP};
      n.s2 = r.s1;
      n.s3 = r.s2;
      n.pin = (r.s2 & r.s3) | (r.pin & (r.s2 ^ r.s3));
      rise = n.pin.sclk & ~r.pin.sclk;
      fall = ~n.pin.sclk & r.pin.sclk;
      // SPI idling low samples on the falling edge, otherwise rising
      samp = (r.pin.mode && !r.idle_hi) ? fall : rise;
      run = !r.mem[`SCC_CTRL][`SCC_B_OSCOFF] && (!r.pin.vlow || r.backup);
      if (!n.pin.vlow) n.sealed = 1'b0;
      n.backup = r.backup ? n.pin.vlow : (n.pin.vlow & n.pin.vbat & !r.sealed);
      if (run && n.pin.xtal && !r.pin.xtal) begin
         if (r.div == 16'(XTAL_DIV - 1)) begin
            n.div = 16'h0000;
            tick = 1'b1;
         end else n.div = r.div + 16'h0001;
      end
      n.tick_d = tick;
      if (tick) n.mem[6:0] = advance(r.mem[6:0]);
      // Link writes land after the increment so they win over it
      if (n.pin.cs && !r.pin.cs && !n.pin.vlow) begin
         n.link = scc_pkg::LK_ADDR;
         n.bits = 3'h0;
         n.idle_hi = n.pin.sclk;
         n.shadow = n.mem[6:0];
      end else if (!n.pin.cs || n.pin.vlow) begin
         n.link = scc_pkg::LK_IDLE;
         n.bits = 3'h0;
         n.oe = 1'b0;
      end else if (r.link != scc_pkg::LK_IDLE && samp) begin
         n.shin = {r.shin[6:0], n.pin.serial_in_line};
         n.bits = r.bits + 3'h1;
         // Next bit goes out right after the host samples, for the most setup time
         if (r.link == scc_pkg::LK_DATA && !r.wr) begin
            n.serial_out_line = r.shout[7];
            n.shout = {r.shout[6:0], 1'b0};
         end
         if (r.bits == 3'h7) begin
            done = 1'b1;
            if (r.link == scc_pkg::LK_ADDR) begin
               n.link = scc_pkg::LK_DATA;
               n.wr = n.shin[`SCC_B_RW];
               n.addr = n.shin[6:0];
            end else begin
               if (r.wr) n.mem = wr_byte(n.mem, r.addr, n.shin);
               n.addr = nxt(r.addr);
               if (r.addr == `SCC_CLK_LAST) n.shadow = n.mem[6:0];
            end
            n.shout = rd(n.mem, n.shadow, n.addr);
            n.serial_out_line = n.shout[7];
            n.shout = {n.shout[6:0], 1'b0};
            n.oe = !n.wr;
         end
      end
      if (r.ahb_v && r.ahb_w && !r.ahb_idx[7]) n.mem = wr_byte(n.mem, r.ahb_idx[6:0], HWDATA[7:0]);
      // Flags are set after all writes, so a match beats a clear
      if (r.tick_d && amatch(r.mem, `SCC_ALM0)) n.mem[`SCC_STAT][`SCC_B_F0] = 1'b1;
      if (r.tick_d && amatch(r.mem, `SCC_ALM1)) n.mem[`SCC_STAT][`SCC_B_F1] = 1'b1;
      n.ahb_v = HSEL & HREADY & HTRANS[1];
      n.ahb_w = HWRITE;
      n.ahb_idx = HADDR[9:2];
      if (n.ahb_v && !HWRITE) begin
         if (!HADDR[9]) n.rdata = {24'h000000, n.mem[HADDR[8:2]]};
         else if (HADDR[9:2] == `SCC_PWR_IDX)
            n.rdata = {28'h0000000, r.sealed, r.backup, r.pin.vlow, r.link != scc_pkg::LK_IDLE};
         else n.rdata = 32'h00000000;
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         r <= '0;
         // Supply sense starts low so reset cannot drop the seal before the filter settles
         r.s1.vlow <= 1'b1;
         r.s2.vlow <= 1'b1;
         r.s3.vlow <= 1'b1;
         r.pin.vlow <= 1'b1;
         r.mem[`SCC_DAY] <= `SCC_ONE;
         r.mem[`SCC_DATE] <= `SCC_ONE;
         r.mem[`SCC_MON] <= `SCC_ONE;
         r.sealed <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign HRDATA = r.rdata;
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign SERIAL_OUT_LINE = r.serial_out_line;
   assign SERIAL_OUT_OE = r.oe;
   assign SUPPLY_FAIL_N = !r.pin.vlow;
   assign BACKUP_SELECT = r.backup;
   // Merged routing puts both alarms on output A
   assign ALARM_IRQ_A_N = !((r.mem[`SCC_STAT][`SCC_B_F0] && r.mem[`SCC_CTRL][`SCC_B_A0IE]) ||
                           (r.mem[`SCC_CTRL][`SCC_B_INTCN] && r.mem[`SCC_STAT][`SCC_B_F1] &&
                            r.mem[`SCC_CTRL][`SCC_B_A1IE]));
   assign ALARM_IRQ_B_N = !(!r.mem[`SCC_CTRL][`SCC_B_INTCN] && r.mem[`SCC_STAT][`SCC_B_F1] &&
                            r.mem[`SCC_CTRL][`SCC_B_A1IE]);

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_N);

   fail_follows_a: assert property (MAIN_BELOW_THRESHOLD [*4] |-> ##[1:3] !SUPPLY_FAIL_N)
      else $error("supply fail not flagged");
   drive_read_a: assert property (SERIAL_OUT_OE |-> r.link == scc_pkg::LK_DATA && !r.wr)
      else $error("data line driven outside read");
   cs_release_a: assert property ($fell(r.pin.cs) |-> r.link == scc_pkg::LK_IDLE && !SERIAL_OUT_OE)
      else $error("link not released on select fall");
   block_low_a: assert property (r.pin.vlow |-> r.link == scc_pkg::LK_IDLE && !SERIAL_OUT_OE)
      else $error("link active while supply low");
   seal_hold_a: assert property (r.sealed |-> !BACKUP_SELECT)
      else $error("backup used while sealed");
   clk_wrap_a: assert property (done && r.link == scc_pkg::LK_DATA && r.addr == `SCC_CLK_LAST
                                |=> r.addr == `SCC_SEC)
      else $error("clock pointer did not wrap");
   ram_wrap_a: assert property (done && r.link == scc_pkg::LK_DATA && r.addr == `SCC_RAM_LAST
                                |=> r.addr == `SCC_RAM_FIRST)
      else $error("ram pointer did not wrap");
   osc_stop_a: assert property (r.mem[`SCC_CTRL][`SCC_B_OSCOFF] && !r.ahb_v && r.link == scc_pkg::LK_IDLE
                                |=> r.mem[`SCC_SEC] == $past(r.mem[`SCC_SEC]))
      else $error("time advanced with oscillator off");
   alarm_flag_a: assert property (r.tick_d && amatch(r.mem, `SCC_ALM0)
                                  |=> r.mem[`SCC_STAT][`SCC_B_F0])
      else $error("alarm flag not set on match");
   irq_route_a: assert property (r.mem[`SCC_STAT][`SCC_B_F1] && r.mem[`SCC_CTRL][`SCC_B_A1IE]
                                 |-> (r.mem[`SCC_CTRL][`SCC_B_INTCN] ? !ALARM_IRQ_A_N && ALARM_IRQ_B_N
                                                                     : !ALARM_IRQ_B_N))
      else $error("alarm routed to wrong output");
   backup_enter_a: assert property (n.pin.vlow && n.pin.vbat && !r.sealed |=> BACKUP_SELECT)
      else $error("backup supply not selected");
   seal_break_a: assert property (r.sealed && !n.pin.vlow |=> !r.sealed)
      else $error("seal kept after main supply rose");
   unselected_idle_a: assert property (!r.pin.cs |-> r.link == scc_pkg::LK_IDLE)
      else $error("link active without select");
   shift_hold_a: assert property (r.link != scc_pkg::LK_IDLE && r.pin.cs && n.pin.cs && !n.pin.vlow && !samp
                                  |=> r.bits == $past(r.bits))
      else $error("bit counted without a link clock edge");

   read_seen_c: cover property ($rose(SERIAL_OUT_OE));
   write_seen_c: cover property (done && r.link == scc_pkg::LK_DATA && r.wr);
   alarm_seen_c: cover property ($rose(r.mem[`SCC_STAT][`SCC_B_F0]));
   backup_seen_c: cover property ($fell(BACKUP_SELECT));
   idle_low_c: cover property (done && r.link == scc_pkg::LK_DATA && !r.idle_hi);
endmodule : scc_top

/* File: tb/scc_host_model.sv */
// Serial link host model: drives select, clock and data, reads back
`timescale 1ns/1ps
module scc_host_model (
   // Link pins
   output logic      cs,
   output logic      sclk,
   output logic      dout,
   input  wire logic din
);
   logic [7:0] wbuf [4];
   logic [7:0] rbuf [4];
   logic       idle = 1'b1;
   initial begin
      cs   = 1'b0;
      sclk = idle; // The device learns the idle level at select rise
      dout = 1'b0;
   end
   // Read bit taken late in the launch phase because the device answers a few clocks after each edge
   task automatic shift(input logic [7:0] tx, input logic rel, input int nb, output logic [7:0] rx);
      for (int i = 7; i > 7 - nb; i--) begin
         sclk = ~idle;
         dout = rel ? ~dout : tx[i];
         #95;
         rx[i] = din;
         #5;
         sclk = idle;
         #100;
      end
   endtask : shift
   // A cut above zero shortens every data byte to that many bits before select drops
   task automatic xfer(input logic wr, input logic [6:0] a, input int n, input int cut);
      logic [7:0] rx;
      sclk = idle;
      cs = 1'b1;
      #200;
      shift({wr, a}, 1'b0, 8, rx);
      for (int k = 0; k < n; k++) begin
         shift(wbuf[k], !wr, (cut > 0) ? cut : 8, rx);
         rbuf[k] = rx;
      end
      #100;
      cs = 1'b0;
      #400;
   endtask : xfer
endmodule : scc_host_model

/* File: tb/testbench.sv */
// Self-checking bench for the serial calendar clock
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin miscompares++; $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
   logic        mclk, rst_n, hsel, hwrite, hreadyout, hresp, cs, sclk, hd, hin, sin, mode, serial_out_line, oe;
   logic        xtal, xrun, thr, bkp, pfail_n, bsel, irq_a_n, irq_b_n;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [7:0]  d, a;
   int          miscompares, n_compared;
   logic [7:0]  cal [3][5] = '{'{8'h23, 8'h23, 8'h00, 8'h01, 8'h03}, '{8'h23, 8'h24, 8'h00, 8'h29, 8'h02},
                               '{8'h71, 8'h24, 8'h52, 8'h29, 8'h02}};
   logic [7:0]  ctl [3] = '{8'h01, 8'h06, 8'h02};
   assign sin = (!mode && oe) ? serial_out_line : hd;
   // A released data line reads back as the inverse of what the host drove last
   assign hin = oe ? serial_out_line : ~hd;
   always #12.5 mclk = ~mclk;
   always #250 xtal = xrun ? ~xtal : xtal;
   scc_top #(.XTAL_DIV(4)) i_dut (
      .MCLK(mclk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
      .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
      .HRESP(hresp), .CHIP_SELECT_LINE(cs), .SERIAL_CLOCK(sclk), .SERIAL_IN_LINE(sin),
      .INTERFACE_SELECT(mode), .SERIAL_OUT_LINE(serial_out_line), .SERIAL_OUT_OE(oe), .XTAL_CLOCK(xtal),
      .MAIN_BELOW_THRESHOLD(thr), .MAIN_BELOW_BACKUP(bkp), .SUPPLY_FAIL_N(pfail_n),
      .BACKUP_SELECT(bsel), .ALARM_IRQ_A_N(irq_a_n), .ALARM_IRQ_B_N(irq_b_n)
   );
   scc_host_model i_host (.cs(cs), .sclk(sclk), .dout(hd), .din(hin));
   function automatic logic [7:0] nxt(input logic [7:0] x);
      return (x == 8'h7F) ? 8'h20 : (x == 8'h1F) ? 8'h00 : x + 8'h01;
   endfunction : nxt
   function automatic logic [7:0] reset_val(input int i);
      return (i >= 3 && i <= 5) ? 8'h01 : 8'h00;
   endfunction : reset_val
   task automatic ahb(input logic w, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge mclk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {22'h0, idx, 2'b00};
      hwrite <= w;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb
   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      logic [31:0] x;
      ahb(1'b1, idx, {24'h0, v}, x);
   endtask : wr
   task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
      logic [31:0] x;
      ahb(1'b0, idx, 32'h0, x);
      `CHK(x, {24'h0, e})
   endtask : rchk
   task automatic supply(input logic t, input logic b);
      @(posedge mclk);
      thr <= t;
      bkp <= b;
      repeat (8) @(posedge mclk);
   endtask : supply
   task automatic wait_irq(input logic b);
      for (int k = 0; k < 400; k++) begin
         @(negedge mclk);
         if ((b ? irq_b_n : irq_a_n) === 1'b0) break;
      end
   endtask : wait_irq
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask : done
   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : finish_test
   initial begin
      #2ms;
      miscompares++;
      finish_test;
   end
   initial begin
      {mclk, rst_n, hsel, haddr, htrans, hwrite, hwdata, xtal, xrun} = '0;
      {hsize, mode, thr, bkp} = {3'b010, 3'b111}; // Battery attached, main supply absent
      void'($urandom(32'hBAD9));
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (8) @(posedge mclk);
      `CHK(bsel, 1'b0)
      `CHK(pfail_n, 1'b0)
      rchk(8'h80, 8'h0A);
      for (int i = 0; i < 7; i++) rchk(i[7:0], reset_val(i));
      supply(1'b0, 1'b0);
      `CHK(pfail_n, 1'b1)
      supply(1'b1, 1'b1);
      `CHK(bsel, 1'b1)
      rchk(8'h80, 8'h06);
      supply(1'b0, 1'b0);
      `CHK(bsel, 1'b0)
      done("power");
      for (int k = 0; k < 8; k++) begin
         a = 8'h20 + 8'($urandom_range(95, 0));
         d = 8'($urandom);
         wr(a, d);
         rchk(a, d);
      end
      wr(8'h12, 8'hA5);
      rchk(8'h12, 8'h00);
      done("storage");
      // Third pass runs SPI with the link clock idling low
      for (int m = 0; m < 3; m++) begin
         @(posedge mclk);
         mode <= (m != 0);
         i_host.idle = (m != 2);
         repeat (4) @(posedge mclk);
         i_host.wbuf[0] = 8'($urandom);
         i_host.wbuf[1] = 8'($urandom);
         i_host.xfer(1'b1, 7'h7F, 2, 0);
         rchk(8'h7F, i_host.wbuf[0]);
         rchk(nxt(8'h7F), i_host.wbuf[1]);
         d = 8'($urandom_range(59, 0));
         wr(8'h00, d);
         i_host.xfer(1'b0, 7'h1F, 2, 0);
         `CHK(i_host.rbuf[1], d)
         d = 8'($urandom);
         wr(8'h40, d);
         i_host.xfer(1'b0, 7'h40, 1, 0);
         `CHK(i_host.rbuf[0], d)
         `CHK(oe, 1'b0)
      end
      done("link");
      d = 8'($urandom);
      wr(8'h23, d);
      i_host.wbuf[0] = ~d;
      i_host.xfer(1'b1, 7'h23, 1, 4);
      rchk(8'h23, d);
      i_host.xfer(1'b0, 7'h23, 1, 4);
      `CHK(oe, 1'b0)
      supply(1'b1, 1'b0);
      i_host.xfer(1'b1, 7'h23, 1, 0);
      supply(1'b0, 1'b0);
      rchk(8'h23, d);
      done("abort and block");
      xrun = 1'b1;
      for (int i = 0; i < 3; i++) begin
         wr(8'h0F, 8'h80);
         wr(8'h00, 8'h59);
         wr(8'h01, 8'h59);
         wr(8'h02, cal[i][0]);
         wr(8'h04, 8'h28);
         wr(8'h05, 8'h02);
         wr(8'h06, cal[i][1]);
         #3000;
         rchk(8'h00, 8'h59);
         wr(8'h0F, 8'h00);
         for (int k = 0; k < 200; k++) begin
            ahb(1'b0, 8'h00, 32'h0, r);
            if (r[7:0] !== 8'h59) break;
         end
         `CHK(r, 32'h0)
         rchk(8'h01, 8'h00);
         rchk(8'h02, cal[i][2]);
         rchk(8'h04, cal[i][3]);
         rchk(8'h05, cal[i][4]);
      end
      done("calendar");
      for (int k = 7; k < 15; k++) wr(k[7:0], 8'h80);
      for (int i = 0; i < 3; i++) begin
         wr(8'h10, 8'h00);
         wr(8'h0F, ctl[i]);
         wait_irq(i == 2);
         `CHK(irq_a_n, i == 2)
         `CHK(irq_b_n, i != 2)
         wr(8'h10, 8'h00);
         @(negedge mclk);
         `CHK(irq_a_n & irq_b_n, 1'b1)
      end
      done("alarms");
      finish_test;
   end
endmodule : testbench
